// ### iec_defines.vh
// constants for the interrupt and event transfer controller
// Operation
// (R1) each node routes to vector or transfer
// (R2) transfer steals exactly one cpu cycle
// (R3) transfer moves byte/word, bumps chosen pointers
// (R4) counter decrements unless continuous mode set
// (R5) counter zero raises node's standard interrupt
// (R6) eight independent event transfer channels
// (R7) node control: request, enable, priority level
// (R8) sixteen priority levels per node
// (R9) preempt only for strictly higher priority
// (R10) every node has its own vector
// (R11) fast pins detect rising, falling, both
// (R12) trap number yields its own vector
// (R13) software sets unassigned node request bits
// (R14) interrupt answer typically within eight clocks
// (R15) vector offset follows trap number table
// (R16) vector is prefix plus four times trap
// (R17) acceptance clears request; disabled stays pending
`ifndef IEC_DEFINES_VH
`define IEC_DEFINES_VH
`define IEC_NODES 16
`define IEC_CHANS 8
// register indices on the plain port
`define IEC_A_NODE 8'h00
`define IEC_A_CHCTL 8'h10
`define IEC_A_SRC 8'h18
`define IEC_A_DST 8'h20
`define IEC_A_EDGE 8'h28
`define IEC_A_SEG 8'h29
`define IEC_A_STAT 8'h2a
`define IEC_A_MASK 8'h2b
// node control fields
`define IEC_F_LVL 3:0
`define IEC_F_EN 6
`define IEC_F_REQ 7
`define IEC_F_ROUTE 8
`define IEC_F_CH 11:9
// channel control fields
`define IEC_F_CNT 7:0
`define IEC_F_CONT 8
`define IEC_F_BYTE 9
`define IEC_F_INCS 10
`define IEC_F_INCD 11
// trap numbers of the peripheral base, fast pin and free nodes
`define IEC_TRAP_CC0 8'h10
`define IEC_TRAP_EXT0 8'h20
`define IEC_TRAP_EXT1 8'h21
`define IEC_TRAP_FREE0 8'h28
`define IEC_TRAP_FREE1 8'h29
`define IEC_SEG_RST 8'h00
// first node index fed by the fast pins, one node per pin
`define IEC_EXT_NODE 12
`endif

// ### iec_ctrl.v
// interrupt controller with eight-channel event transfer engine
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "iec_defines.vh"
module iec_ctrl (
  // clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // register port
  input wire [7:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [15:0] reg_rdata_out,
  // request sources
  input wire [11:0] periph_req_in,
  input wire [1:0] ext_pin_in,
  // cpu standard interrupt side
  input wire [3:0] cpu_level_in,
  input wire cpu_ack_in,
  output reg irq_req_out,
  output reg [23:0] irq_vector_out,
  output reg [3:0] irq_level_out,
  output reg [3:0] irq_node_out,
  // software trap
  input wire trap_in,
  input wire [6:0] trap_num_in,
  output reg trap_valid_out,
  output reg [23:0] trap_vector_out,
  // event transfer engine cycle steal
  input wire cpu_steal_in,
  output reg etx_req_out,
  output reg [15:0] etx_src_out,
  output reg [15:0] etx_dst_out,
  output reg etx_byte_out,
  output reg [2:0] etx_chan_out,
  // channel-empty interrupt
  output wire irq_out
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // highest level among masked nodes, lowest index on a tie
  function [4:0] iec_pick;
    input [15:0] m;
    input [63:0] p;
    integer k;
    reg [3:0] bl;
    reg [3:0] bi;
    reg v;
    begin
      bl = 4'h0;
      bi = 4'h0;
      v = 1'b0;
      for (k = 0; k < `IEC_NODES; k = k + 1) begin
        if (m[k] && (!v || p[k*4 +: 4] > bl)) begin
          v = 1'b1;
          bl = p[k*4 +: 4];
          bi = k[3:0];
        end
      end
      iec_pick = {v, bi};
    end
  endfunction

  // fixed trap number of each node
  function [7:0] iec_trap;
    input [3:0] n;
    begin
      case (n)
        4'hc: iec_trap = `IEC_TRAP_EXT0;
        4'hd: iec_trap = `IEC_TRAP_EXT1;
        4'he: iec_trap = `IEC_TRAP_FREE0;
        4'hf: iec_trap = `IEC_TRAP_FREE1;
        default: iec_trap = `IEC_TRAP_CC0 + {4'h0, n};
      endcase
    end
  endfunction

  // write strobe aimed at one register index
  function iec_wr_hit;
    input wr;
    input [7:0] a;
    input [7:0] idx;
    begin
      iec_wr_hit = wr & (a == idx);
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [63:0] lvl_reg;
  reg [15:0] en_reg;
  reg [15:0] req_reg;
  reg [15:0] route_reg;
  reg [47:0] ch_reg;
  reg [7:0] cnt_reg [0:7];
  reg [7:0] cont_reg;
  reg [7:0] byte_reg;
  reg [7:0] incs_reg;
  reg [7:0] incd_reg;
  reg [15:0] src_reg [0:7];
  reg [15:0] dst_reg [0:7];
  reg [3:0] rise_reg;
  reg [7:0] seg_reg;
  reg [7:0] stat_reg;
  reg [7:0] mask_reg;
  reg [3:0] etx_node_reg;
  reg [1:0] s1_reg;
  reg [1:0] s2_reg;
  reg [1:0] s3_reg;
  reg [1:0] pin_lvl_reg;

  // ----------------------------------------------------------------
  // fast pin edge detection
  // ----------------------------------------------------------------
  reg [1:0] ext_edge;
  integer e;
  always @* begin
    ext_edge = 2'b00;
    for (e = 0; e < 2; e = e + 1) begin
      if (s2_reg[e] == s3_reg[e] && s3_reg[e] != pin_lvl_reg[e]) begin
        ext_edge[e] = (s3_reg[e] & rise_reg[e]) | (~s3_reg[e] & rise_reg[e+2]); // [R11]
      end
    end
  end

  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_reg <= 2'b00;
      s2_reg <= 2'b00;
      s3_reg <= 2'b00;
      pin_lvl_reg <= 2'b00;
    end else begin
      s1_reg <= ext_pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        pin_lvl_reg <= s3_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  reg [15:0] etx_mode;
  reg [15:0] etx_mask;
  reg [15:0] std_mask;
  reg [2:0] chn;
  integer i;
  always @* begin
    etx_mode = 16'h0000;
    etx_mask = 16'h0000;
    std_mask = 16'h0000;
    chn = 3'h0;
    for (i = 0; i < `IEC_NODES; i = i + 1) begin
      chn = ch_reg[i*3 +: 3];
      // an exhausted channel hands its node back to vectored service
      etx_mode[i] = route_reg[i] & ((cnt_reg[chn] != 8'h00) | cont_reg[chn]); // [R1] [R5]
      etx_mask[i] = req_reg[i] & en_reg[i] & etx_mode[i]; // [R17]
      std_mask[i] = req_reg[i] & en_reg[i] & ~etx_mode[i]
        & (lvl_reg[i*4 +: 4] > cpu_level_in); // [R9] [R17]
    end
  end

  wire [4:0] etx_pick = iec_pick(etx_mask, lvl_reg); // [R8]
  wire [4:0] std_pick = iec_pick(std_mask, lvl_reg); // [R8]
  wire [2:0] pick_ch = ch_reg[etx_pick[3:0]*3 +: 3];
  wire steal = cpu_steal_in & etx_req_out;
  wire ack = cpu_ack_in & irq_req_out;
  wire [2:0] sch = etx_chan_out;
  wire sch_empty = steal & ~cont_reg[sch] & (cnt_reg[sch] == 8'h01);

  // ----------------------------------------------------------------
  // node control registers
  // ----------------------------------------------------------------
  wire [15:0] hw_set = {2'b00, ext_edge, periph_req_in};
  reg [15:0] req_next;
  integer n;
  always @* begin
    req_next = req_reg;
    for (n = 0; n < `IEC_NODES; n = n + 1) begin
      if (iec_wr_hit(reg_wr_in, reg_addr_in, `IEC_A_NODE + n[7:0])) begin
        req_next[n] = reg_wdata_in[`IEC_F_REQ]; // [R13]
      end
      if (ack && irq_node_out == n[3:0]) begin
        req_next[n] = 1'b0; // [R17]
      end
      // a transfer that empties the counter keeps the request for the vector
      if (steal && etx_node_reg == n[3:0] && !sch_empty) begin
        req_next[n] = 1'b0;
      end
      if (hw_set[n]) begin
        req_next[n] = 1'b1;
      end
    end
  end

  integer w;
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lvl_reg <= 64'h0;
      en_reg <= 16'h0000;
      req_reg <= 16'h0000;
      route_reg <= 16'h0000;
      ch_reg <= 48'h0;
    end else begin
      req_reg <= req_next;
      for (w = 0; w < `IEC_NODES; w = w + 1) begin
        if (iec_wr_hit(reg_wr_in, reg_addr_in, `IEC_A_NODE + w[7:0])) begin
          lvl_reg[w*4 +: 4] <= reg_wdata_in[`IEC_F_LVL]; // [R7] [R8]
          en_reg[w] <= reg_wdata_in[`IEC_F_EN]; // [R7]
          route_reg[w] <= reg_wdata_in[`IEC_F_ROUTE]; // [R1]
          ch_reg[w*3 +: 3] <= reg_wdata_in[`IEC_F_CH];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // event transfer channels
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `IEC_CHANS; g = g + 1) begin : chan
      wire svc = steal && sch == g;
      always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          cnt_reg[g] <= 8'h00;
          cont_reg[g] <= 1'b0;
          byte_reg[g] <= 1'b0;
          incs_reg[g] <= 1'b0;
          incd_reg[g] <= 1'b0;
          src_reg[g] <= 16'h0000;
          dst_reg[g] <= 16'h0000;
        end else begin
          if (reg_wr_in && reg_addr_in == `IEC_A_CHCTL + g) begin
            cnt_reg[g] <= reg_wdata_in[`IEC_F_CNT];
            cont_reg[g] <= reg_wdata_in[`IEC_F_CONT];
            byte_reg[g] <= reg_wdata_in[`IEC_F_BYTE];
            incs_reg[g] <= reg_wdata_in[`IEC_F_INCS];
            incd_reg[g] <= reg_wdata_in[`IEC_F_INCD];
          end else if (svc && !cont_reg[g]) begin
            cnt_reg[g] <= cnt_reg[g] - 8'h01; // [R4]
          end
          if (reg_wr_in && reg_addr_in == `IEC_A_SRC + g) begin
            src_reg[g] <= reg_wdata_in;
          end else if (svc && incs_reg[g]) begin
            src_reg[g] <= src_reg[g] + (byte_reg[g] ? 16'h0001 : 16'h0002); // [R3]
          end
          if (reg_wr_in && reg_addr_in == `IEC_A_DST + g) begin
            dst_reg[g] <= reg_wdata_in;
          end else if (svc && incd_reg[g]) begin
            dst_reg[g] <= dst_reg[g] + (byte_reg[g] ? 16'h0001 : 16'h0002); // [R3]
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // cpu facing outputs
  // ----------------------------------------------------------------
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      etx_req_out <= 1'b0;
      etx_src_out <= 16'h0000;
      etx_dst_out <= 16'h0000;
      etx_byte_out <= 1'b0;
      etx_chan_out <= 3'h0;
      etx_node_reg <= 4'h0;
      irq_req_out <= 1'b0;
      irq_vector_out <= 24'h0;
      irq_level_out <= 4'h0;
      irq_node_out <= 4'h0;
      trap_valid_out <= 1'b0;
      trap_vector_out <= 24'h0;
    end else begin
      // one steal per offer, then re-arbitrate the next cycle
      if (steal || etx_req_out) begin
        etx_req_out <= 1'b0; // [R2]
      end else begin
        etx_req_out <= etx_pick[4]; // [R1] [R6]
        etx_node_reg <= etx_pick[3:0];
        etx_chan_out <= pick_ch;
        etx_src_out <= src_reg[pick_ch];
        etx_dst_out <= dst_reg[pick_ch];
        etx_byte_out <= byte_reg[pick_ch]; // [R3]
      end
      // offer follows the current winner until taken, then one cycle low before the next
      if (ack || irq_req_out) begin
        irq_req_out <= ~ack & std_pick[4];
      end else begin
        irq_req_out <= std_pick[4]; // [R9] [R14]
      end
      if (!irq_req_out || !ack) begin
        irq_node_out <= std_pick[3:0];
        irq_level_out <= lvl_reg[std_pick[3:0]*4 +: 4];
        irq_vector_out <= {seg_reg, 6'h00, iec_trap(std_pick[3:0]), 2'b00}; // [R10] [R15] [R16]
      end
      trap_valid_out <= trap_in;
      if (trap_in) begin
        trap_vector_out <= {seg_reg, 7'h00, trap_num_in, 2'b00}; // [R12] [R16]
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration, status and interrupt
  // ----------------------------------------------------------------
  wire [7:0] stat_clr = (reg_wr_in && reg_addr_in == `IEC_A_STAT) ? reg_wdata_in[7:0] : 8'h00;
  wire [7:0] stat_set = sch_empty ? (8'h01 << sch) : 8'h00;
  assign irq_out = |(stat_reg & mask_reg);

  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rise_reg <= 4'h0;
      seg_reg <= `IEC_SEG_RST;
      stat_reg <= 8'h00;
      mask_reg <= 8'h00;
    end else begin
      stat_reg <= (stat_reg & ~stat_clr) | stat_set;
      if (iec_wr_hit(reg_wr_in, reg_addr_in, `IEC_A_EDGE)) begin
        rise_reg <= reg_wdata_in[3:0]; // [R11]
      end
      if (iec_wr_hit(reg_wr_in, reg_addr_in, `IEC_A_SEG)) begin
        seg_reg <= reg_wdata_in[7:0]; // [R16]
      end
      if (iec_wr_hit(reg_wr_in, reg_addr_in, `IEC_A_MASK)) begin
        mask_reg <= reg_wdata_in[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  reg [15:0] rd_mux;
  reg [3:0] ri;
  reg [2:0] rc;
  always @* begin
    rd_mux = 16'h0000;
    ri = reg_addr_in[3:0];
    rc = reg_addr_in[2:0];
    if (reg_addr_in < `IEC_A_CHCTL) begin
      rd_mux = {4'h0, ch_reg[ri*3 +: 3], route_reg[ri], req_reg[ri], en_reg[ri], 2'b00,
        lvl_reg[ri*4 +: 4]};
    end else if (reg_addr_in < `IEC_A_SRC) begin
      rd_mux = {4'h0, incd_reg[rc], incs_reg[rc], byte_reg[rc], cont_reg[rc], cnt_reg[rc]};
    end else if (reg_addr_in < `IEC_A_DST) begin
      rd_mux = src_reg[rc];
    end else if (reg_addr_in < `IEC_A_EDGE) begin
      rd_mux = dst_reg[rc];
    end else if (reg_addr_in == `IEC_A_EDGE) begin
      rd_mux = {12'h000, rise_reg};
    end else if (reg_addr_in == `IEC_A_SEG) begin
      rd_mux = {8'h00, seg_reg};
    end else if (reg_addr_in == `IEC_A_STAT) begin
      rd_mux = {8'h00, stat_reg};
    end else if (reg_addr_in == `IEC_A_MASK) begin
      rd_mux = {8'h00, mask_reg};
    end
  end

  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 16'h0000;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_mux : 16'h0000;
    end
  end

endmodule

// ### iec_ctrl_props.sv
// port assertions for the interrupt controller
`timescale 1ns/100ps
module iec_props (
  // watched ports
  input wire clk_sys_in,
  input wire rst_n_in,
  input wire reg_rd_in,
  input wire [15:0] reg_rdata_out,
  input wire [3:0] cpu_level_in,
  input wire cpu_ack_in,
  input wire irq_req_out,
  input wire [23:0] irq_vector_out,
  input wire [3:0] irq_level_out,
  input wire [3:0] irq_node_out,
  input wire trap_in,
  input wire [6:0] trap_num_in,
  input wire trap_valid_out,
  input wire [23:0] trap_vector_out,
  input wire etx_req_out
);
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  rd_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
    else $error("read data outside read slot");
  offer_once_a: assert property (etx_req_out |=> !etx_req_out)
    else $error("transfer offer longer than one cycle");
  level_above_a: assert property (irq_req_out |-> irq_level_out > $past(cpu_level_in))
    else $error("offer not above cpu level");
  periph_vec_a: assert property (irq_req_out && irq_node_out < 4'hc |->
    irq_vector_out[15:0] == {6'h00, 8'h10 + {4'h0, irq_node_out}, 2'h0})
    else $error("peripheral node vector wrong");
  fast_vec_a: assert property (irq_req_out && irq_node_out > 4'hb |->
    irq_vector_out[15:0] == {6'h00, 4'h2, irq_node_out[1], 2'h0, irq_node_out[0], 2'h0})
    else $error("pin or free node vector wrong");
  trap_answer_a: assert property (trap_in |=> trap_valid_out &&
    trap_vector_out[15:0] == {7'h00, $past(trap_num_in), 2'h0})
    else $error("trap vector wrong");
  trap_cause_a: assert property (trap_valid_out |-> $past(trap_in))
    else $error("trap answer without trap");
  ack_release_a: assert property (irq_req_out && cpu_ack_in |=>
    !irq_req_out || irq_node_out != $past(irq_node_out))
    else $error("acked node offered again");
endmodule
bind iec_ctrl iec_props u_props (
  .clk_sys_in, .rst_n_in, .reg_rd_in, .reg_rdata_out, .cpu_level_in, .cpu_ack_in,
  .irq_req_out, .irq_vector_out, .irq_level_out, .irq_node_out, .trap_in, .trap_num_in,
  .trap_valid_out, .trap_vector_out, .etx_req_out
);

// ### iec_cpu_model.sv
// cpu core model: accepts vectors and grants stolen cycles
`timescale 1ns/100ps
module iec_cpu_model (
  // offers from the controller
  input wire irq_req_in,
  input wire etx_req_in,
  // answer speed control
  input wire ack_en_in,
  input wire steal_en_in,
  // answers to the controller
  output wire cpu_ack_out,
  output wire cpu_steal_out
);
  // answers only inside an offer cycle, so each offer gets at most one answer
  assign cpu_ack_out = ack_en_in & irq_req_in;
  assign cpu_steal_out = steal_en_in & etx_req_in;
endmodule

// ### interrupt_and_event_transfer_ctrl_bench.sv
// self-checking bench for the interrupt and event transfer controller
`timescale 1ns/100ps
`include "iec_defines.vh"
module interrupt_and_event_transfer_ctrl_bench;
  reg clk_sys_in, rst_n_in, reg_wr_in, reg_rd_in, trap_in, ack_en, steal_en;
  reg [7:0] reg_addr_in;
  reg [15:0] reg_wdata_in;
  reg [11:0] periph_req_in;
  reg [1:0] ext_pin_in;
  reg [3:0] cpu_level_in;
  reg [6:0] trap_num_in;
  wire cpu_ack_in, cpu_steal_in, irq_req_out, trap_valid_out, etx_req_out, etx_byte_out;
  wire irq_out;
  wire [15:0] reg_rdata_out, etx_src_out, etx_dst_out;
  wire [23:0] irq_vector_out, trap_vector_out;
  wire [3:0] irq_level_out, irq_node_out;
  wire [2:0] etx_chan_out;
  integer miscompares, n_compared, k, i;
  iec_ctrl u_dut (.*);
  iec_cpu_model u_cpu (.irq_req_in(irq_req_out), .etx_req_in(etx_req_out), .ack_en_in(ack_en),
    .steal_en_in(steal_en), .cpu_ack_out(cpu_ack_in), .cpu_steal_out(cpu_steal_in));
  initial begin
    clk_sys_in = 1'h0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task chk(input string n, input [23:0] e, input [23:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("wrong value %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task end_sim;
    begin
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'h1;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'h0;
      @(posedge clk_sys_in);
    end
  endtask
  task rd(input [7:0] a, input [15:0] e, input string n);
    begin
      reg_addr_in <= a;
      reg_rd_in <= 1'h1;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'h0;
      #1;
      chk(n, {8'h00, e}, {8'h00, reg_rdata_out});
      @(posedge clk_sys_in);
    end
  endtask
  task pulse(input [11:0] m);
    begin
      periph_req_in <= m;
      @(posedge clk_sys_in);
      periph_req_in <= 12'h000;
    end
  endtask
  task wait_for(input integer etx);
    begin
      k = 0;
      #1;
      while ((etx ? etx_req_out : irq_req_out) !== 1'h1 && k < 20) begin
        @(posedge clk_sys_in);
        #1;
        k = k + 1;
      end
      if (k == 20) begin
        chk("offer wait", 24'h1, 24'h0);
        end_sim;
      end
    end
  endtask
  task offer(input [3:0] nd, input [23:0] v);
    begin
      wait_for(0);
      chk("irq node", {20'h0, nd}, {20'h0, irq_node_out});
      chk("irq vector", v, irq_vector_out);
      @(posedge clk_sys_in);
    end
  endtask
  task xfer(input [15:0] s, input [15:0] d, input [3:0] bc);
    begin
      wait_for(1);
      chk("src", {8'h00, s}, {8'h00, etx_src_out});
      chk("dst", {8'h00, d}, {8'h00, etx_dst_out});
      chk("byte chan", {20'h0, bc}, {20'h0, etx_byte_out, etx_chan_out});
      @(posedge clk_sys_in);
    end
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    {rst_n_in, reg_wr_in, reg_rd_in, trap_in} = 4'h0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 16'h0000;
    periph_req_in = 12'h000;
    ext_pin_in = 2'h0;
    cpu_level_in = 4'h0;
    trap_num_in = 7'h00;
    ack_en = 1'h1;
    steal_en = 1'h1;
    miscompares = 0;
    n_compared = 0;
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'h1;
    rd(`IEC_A_NODE, 16'h0000, "node reset");
    rd(`IEC_A_SEG, {8'h00, `IEC_SEG_RST}, "seg reset");
    wr(`IEC_A_SEG, 16'h0012);
    wr(8'h3f, 16'hffff);
    rd(8'h3f, 16'h0000, "unmapped");
    wr(`IEC_A_NODE + 8'h06, 16'h004f);
    rd(`IEC_A_NODE + 8'h06, 16'h004f, "level f");
    $display("test registers done");
    wr(`IEC_A_NODE, 16'h0045);
    cpu_level_in <= 4'h2;
    pulse(12'h001);
    offer(4'h0, 24'h120040);
    rd(`IEC_A_NODE, 16'h0045, "ack clears");
    wr(`IEC_A_NODE + 8'h01, 16'h0003);
    pulse(12'h002);
    repeat (3) @(posedge clk_sys_in);
    #1;
    chk("disabled", 24'h0, {23'h0, irq_req_out});
    @(posedge clk_sys_in);
    rd(`IEC_A_NODE + 8'h01, 16'h0083, "pending");
    wr(`IEC_A_NODE + 8'h01, 16'h00c3);
    offer(4'h1, 24'h120044);
    $display("test vectored done");
    cpu_level_in <= 4'h7;
    wr(`IEC_A_NODE + 8'h02, 16'h0047);
    wr(`IEC_A_NODE + 8'h03, 16'h0048);
    pulse(12'h00c);
    offer(4'h3, 24'h12004c);
    @(posedge clk_sys_in);
    #1;
    chk("equal level", 24'h0, {23'h0, irq_req_out});
    @(posedge clk_sys_in);
    cpu_level_in <= 4'h0;
    offer(4'h2, 24'h120048);
    wr(`IEC_A_NODE + 8'h0f, 16'h00c3);
    offer(4'hf, 24'h1200a4);
    $display("test priority done");
    for (i = 0; i < 3; i = i + 1) begin
      trap_in <= 1'h1;
      trap_num_in <= (i == 0) ? 7'h10 : (i == 1) ? 7'h44 : 7'h29;
      @(posedge clk_sys_in);
      trap_in <= 1'h0;
      #1;
      chk("trap valid", 24'h1, {23'h0, trap_valid_out});
      chk("trap vector", {8'h12, 7'h00, trap_num_in, 2'h0}, trap_vector_out);
      @(posedge clk_sys_in);
    end
    $display("test trap done");
    wr(`IEC_A_EDGE, 16'h000d);
    ext_pin_in <= 2'h3;
    repeat (6) @(posedge clk_sys_in);
    rd(`IEC_A_NODE + 8'h0c, 16'h0080, "pin0 rise");
    rd(`IEC_A_NODE + 8'h0d, 16'h0000, "pin1 rise");
    wr(`IEC_A_NODE + 8'h0c, 16'h0000);
    ext_pin_in <= 2'h0;
    repeat (6) @(posedge clk_sys_in);
    rd(`IEC_A_NODE + 8'h0c, 16'h0080, "pin0 fall");
    rd(`IEC_A_NODE + 8'h0d, 16'h0080, "pin1 fall");
    $display("test pins done");
    wr(`IEC_A_CHCTL, 16'h0c02);
    wr(`IEC_A_SRC, 16'h1000);
    wr(`IEC_A_DST, 16'h2000);
    wr(`IEC_A_NODE + 8'h04, 16'h0141);
    pulse(12'h010);
    xfer(16'h1000, 16'h2000, 4'h0);
    pulse(12'h010);
    xfer(16'h1002, 16'h2002, 4'h0);
    offer(4'h4, 24'h120050);
    chk("masked", 24'h0, {23'h0, irq_out});
    wr(`IEC_A_MASK, 16'h0001);
    chk("unmasked", 24'h1, {23'h0, irq_out});
    rd(`IEC_A_STAT, 16'h0001, "status");
    rd(`IEC_A_CHCTL, 16'h0c00, "count");
    rd(`IEC_A_SRC, 16'h1004, "src ptr");
    wr(`IEC_A_STAT, 16'h0001);
    chk("cleared", 24'h0, {23'h0, irq_out});
    wr(`IEC_A_CHCTL + 8'h07, 16'h0703);
    wr(`IEC_A_SRC + 8'h07, 16'h3000);
    wr(`IEC_A_DST + 8'h07, 16'h4000);
    wr(`IEC_A_NODE + 8'h05, 16'h0f41);
    steal_en <= 1'h0;
    pulse(12'h020);
    repeat (4) @(posedge clk_sys_in);
    steal_en <= 1'h1;
    xfer(16'h3000, 16'h4000, 4'hf);
    rd(`IEC_A_CHCTL + 8'h07, 16'h0703, "continuous");
    rd(`IEC_A_SRC + 8'h07, 16'h3001, "byte src");
    rd(`IEC_A_DST + 8'h07, 16'h4000, "fixed dst");
    $display("test transfer done");
    end_sim;
  end
endmodule
